// ===== hw/psef_pkg.sv
// Package for the processor status and error flag block
package psef_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] ENA_OFS = 8'h04;
	localparam logic [7:0] ERAL_OFS = 8'h08;
	localparam logic [7:0] ERAH_OFS = 8'h0C;
	localparam logic [7:0] PFWL_OFS = 8'h10;
	localparam logic [7:0] PFWH_OFS = 8'h14;
	localparam logic [7:0] SWEEP_OFS = 8'h18;
	// Control word fields, bit n of the 36-bit word sits at bus bit 35-n
	localparam int ENA_SET_POS = 15;
	localparam int ENA_CLR_POS = 14;
	localparam int FLG_CLR_POS = 13;
	localparam int FLG_SET_POS = 12;
	localparam int SEL_LSB = 4;
	localparam int CHAN_LSB = 0;
	localparam int HOLD_POS = 16;
	localparam int BUSY_POS = 17;
	// Flag vector positions, bit 7 is control word bit 24
	localparam int F_BUS = 7;
	localparam int F_ABSENT = 6;
	localparam int F_IO_PAGE_FAILURE_FLAG = 5;
	localparam int F_BUFPAR = 4;
	localparam int F_DIRPAR = 3;
	localparam int F_ADRPAR = 2;
	localparam int F_PWR = 1;
	localparam int F_SWEEP = 0;
	localparam logic [7:0] ERR_MASK = 8'hFE;
	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] ENA_RST = 8'h00;
	localparam logic [2:0] CHAN_RST = 3'h0;
	// Page fault word
	localparam logic [5:0] PF_CODE = 6'h16;
	localparam logic [8:0] PF_TABLE_LOC = 9'h140;
	localparam int PF_LEGACY_LSB = 18;
	// Cache clearer
	localparam logic [9:0] CLEARER_DEV = 10'h00C;
	localparam int SW_PAGE_LSB = 0;
	localparam int SW_OP_LSB = 9;
	localparam int SW_DEV_LSB = 12;
	typedef enum logic [2:0] {
		PSEF_OP_INV_ALL = 3'h0,
		PSEF_OP_WB_ALL = 3'h1,
		PSEF_OP_UNLOAD_ALL = 3'h2,
		PSEF_OP_INV_PAGE = 3'h3,
		PSEF_OP_WB_PAGE = 3'h4,
		PSEF_OP_UNLOAD_PAGE = 3'h5
	} psef_op_t;
	typedef enum logic [2:0] {
		PSEF_SW_IDLE = 3'b001,
		PSEF_SW_REQ = 3'b010,
		PSEF_SW_RUN = 3'b100
	} psef_sw_state_t;
	// Error reports from the memory control unit and memory adapter
	typedef struct packed {
		logic bus_fault;
		logic absent;
		logic addr_parity;
		logic buffer_parity;
		logic dir_parity;
	} psef_mem_err_t;
	// Sweep request towards the memory control unit
	typedef struct packed {
		logic req;
		logic whole;
		logic writeback;
		logic invalidate;
		logic [8:0] page;
	} psef_sweep_t;
endpackage

// ===== hw/psef_top.sv
// Processor status flags, interrupt enables, error hold and cache sweep control
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
// Functional notes
// R1: Two 8-bit registers: status flags and per-flag interrupt enables.
// R2: Interrupt requested on assigned channel when any enabled flag is set.
// R3: Control word bit 20 sets enables selected by bits 24 to 31.
// R4: Control word bit 21 clears enables selected by bits 24 to 31.
// R5: Enables stay set until software clears them or reset.
// R6: Bit 23 sets selected flags, bit 22 clears them.
// R7: Adapter gives bus error, absent memory, address parity; memory unit gives two more.
// R8: Adapter acknowledges first, then reports address parity within 125 ns.
// R9: Memory unit latches failing address and reports parity with its response.
// R10: Address parity flag sets on next clock after the memory unit reports it.
// R11: Latched address holds buffer word in bits 34-35 and 3-bit origin code.
// R12: Set error flags go back to memory unit; any-error hold freezes the latch.
// R13: Clearing the error flag releases the frozen address latch.
// R14: Memory unit times out 32 us twice before reporting absent memory.
// R15: Absent memory error loads its flag on the status clock, interrupts if enabled.
// R16: Every external error sets flag, interrupts, feeds back and sets hold.
// R17: Buffer parity error also enters the page fault path using the latched address.
// R18: Fault word: code in bits 0-5, address 13-35, legacy zeroes 13-17, location 500.
// R19: Page failure in interrupt cycle sets I/O page flag, dismisses, refetches saved PC.
// R20: Power warning sets power fail flag and requests an interrupt.
// R21: Sweep done flag sets when a cache sweep completes.
// R22: Cache clearer is device 014 with six sweep operations.
// R23: Whole-cache invalidate writes nothing back to core.
// R24: Memory unit responds to sweep request; completion later raises the flag.
// R25: Reset clears all flags and enables.
// R26: Each flag maps to one fixed bit of 24 to 31 in write and read words.
module psef_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Memory control unit
	input wire psef_pkg::psef_mem_err_t mem_err_i,
	input wire logic memory_unit_response_i,
	input wire logic [35:0] error_address_latch_i,
	input wire logic sweep_done_i,
	output logic [7:0] flag_feedback_o,
	output logic any_error_hold_o,
	output psef_pkg::psef_sweep_t sweep_o,
	// Execution unit
	input wire logic legacy_paging_i,
	input wire logic pi_page_fail_i,
	input wire logic [22:0] saved_pc_i,
	output logic page_fault_o,
	output logic [35:0] fault_word_o,
	output logic [8:0] fault_loc_o,
	output logic pi_dismiss_o,
	output logic [22:0] fetch_pc_o,
	// Power controller pin
	input wire logic power_warn_i,
	// Priority interrupt system
	output logic irq_o,
	output logic [2:0] irq_chan_o
);
	logic ack_q;
	logic [31:0] rdat_q;
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] ena_q;
	logic [2:0] chan_q;
	logic hold_q;
	logic irq_q;
	logic pw_s1_q;
	logic pw_s2_q;
	logic pw_s3_q;
	logic [35:0] pfw_q;
	logic pf_q;
	logic dismiss_q;
	logic [22:0] fetch_pc_q;
	psef_pkg::psef_sw_state_t sw_q;
	psef_pkg::psef_sweep_t sweep_q;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic wr_ctl;
	logic wr_sweep;
	logic [7:0] sel;
	logic [7:0] hw_set;
	logic [31:0] status_word;

	// Expand byte enables to a bit mask
	function automatic logic [31:0] psef_sel_mask(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// Test one control word bit under the byte mask
	function automatic logic psef_bit(input logic [31:0] d, input int pos);
		return d[pos];
	endfunction

	// Bus slave: one-cycle ack, write takes effect at the ack edge
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign wmask = psef_sel_mask(wb_sel_i);
	assign wdat = wb_dat_i & wmask;
	assign wr_ctl = wr && (wb_adr_i == psef_pkg::CTRL_OFS);
	assign wr_sweep = wr && (wb_adr_i == psef_pkg::SWEEP_OFS) && (wb_sel_i == 4'hF) &&
		(wb_dat_i[psef_pkg::SW_DEV_LSB +: 10] == psef_pkg::CLEARER_DEV) &&
		(wb_dat_i[psef_pkg::SW_OP_LSB +: 3] <= psef_pkg::PSEF_OP_UNLOAD_PAGE); // [R22]
	assign sel = wdat[psef_pkg::SEL_LSB +: 8]; // [R26]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[psef_pkg::SEL_LSB +: 8] = flags_q; // [R26]
		status_word[psef_pkg::CHAN_LSB +: 3] = chan_q;
		status_word[psef_pkg::HOLD_POS] = hold_q;
		status_word[psef_pkg::BUSY_POS] = (sw_q != psef_pkg::PSEF_SW_IDLE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
			case (wb_adr_i)
				psef_pkg::CTRL_OFS: rdat_q <= status_word;
				psef_pkg::ENA_OFS: rdat_q <= {20'h0_0000, ena_q, 4'h0};
				psef_pkg::ERAL_OFS: rdat_q <= error_address_latch_i[31:0];
				psef_pkg::ERAH_OFS: rdat_q <= {28'h000_0000, error_address_latch_i[35:32]};
				psef_pkg::PFWL_OFS: rdat_q <= pfw_q[31:0];
				psef_pkg::PFWH_OFS: rdat_q <= {28'h000_0000, pfw_q[35:32]};
				psef_pkg::SWEEP_OFS: rdat_q <= {19'h0_0000, sweep_q.whole, sweep_q.writeback,
					sweep_q.invalidate, sweep_q.req, sweep_q.page};
				default: rdat_q <= 32'h0000_0000;
			endcase
		end
	end

	// Power warning pin synchroniser and edge detect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pw_s1_q <= 1'b0;
			pw_s2_q <= 1'b0;
			pw_s3_q <= 1'b0;
		end else begin
			pw_s1_q <= power_warn_i;
			pw_s2_q <= pw_s1_q;
			pw_s3_q <= pw_s2_q;
		end
	end

	// Hardware flag sources
	always_comb begin
		hw_set = 8'h00;
		hw_set[psef_pkg::F_BUS] = mem_err_i.bus_fault; // [R7] [R16]
		hw_set[psef_pkg::F_ABSENT] = mem_err_i.absent & memory_unit_response_i; // [R15]
		hw_set[psef_pkg::F_ADRPAR] = mem_err_i.addr_parity & memory_unit_response_i; // [R10]
		hw_set[psef_pkg::F_BUFPAR] = mem_err_i.buffer_parity; // [R7] [R17]
		hw_set[psef_pkg::F_DIRPAR] = mem_err_i.dir_parity; // [R7]
		hw_set[psef_pkg::F_IO_PAGE_FAILURE_FLAG] = pi_page_fail_i; // [R19]
		hw_set[psef_pkg::F_PWR] = pw_s2_q & ~pw_s3_q; // [R20]
		hw_set[psef_pkg::F_SWEEP] = (sw_q == psef_pkg::PSEF_SW_RUN) & sweep_done_i; // [R21] [R24]
	end

	// Flags: hardware set wins over software clear
	always_comb begin
		flags_d = flags_q;
		if (wr_ctl && psef_bit(wdat, psef_pkg::FLG_CLR_POS)) begin
			flags_d = flags_d & ~sel; // [R6]
		end
		if (wr_ctl && psef_bit(wdat, psef_pkg::FLG_SET_POS)) begin
			flags_d = flags_d | sel; // [R6]
		end
		flags_d = flags_d | hw_set; // [R16]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_q <= psef_pkg::FLAGS_RST; // [R25]
		end else begin
			flags_q <= flags_d; // [R1]
		end
	end

	// Interrupt enables and channel
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ena_q <= psef_pkg::ENA_RST; // [R25] [R5]
			chan_q <= psef_pkg::CHAN_RST;
		end else if (wr_ctl) begin
			if (psef_bit(wdat, psef_pkg::ENA_SET_POS)) begin
				ena_q <= ena_q | sel; // [R3]
			end else if (psef_bit(wdat, psef_pkg::ENA_CLR_POS)) begin
				ena_q <= ena_q & ~sel; // [R4]
			end
			if (wb_sel_i[0]) begin
				chan_q <= wb_dat_i[psef_pkg::CHAN_LSB +: 3];
			end
		end
	end

	// Interrupt request, error hold and feedback
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			irq_q <= |(flags_d & ena_q); // [R2]
			hold_q <= |(flags_d & psef_pkg::ERR_MASK); // [R12] [R13]
		end
	end

	// Buffer parity page fault word and interrupt-cycle page failure
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pfw_q <= 36'h0_0000_0000;
			pf_q <= 1'b0;
			dismiss_q <= 1'b0;
			fetch_pc_q <= 23'h00_0000;
		end else begin
			pf_q <= mem_err_i.buffer_parity & ~flags_q[psef_pkg::F_BUFPAR]; // [R17]
			dismiss_q <= pi_page_fail_i; // [R19]
			if (pi_page_fail_i) begin
				fetch_pc_q <= saved_pc_i; // [R19]
			end
			if (mem_err_i.buffer_parity & ~flags_q[psef_pkg::F_BUFPAR]) begin
				pfw_q <= {psef_pkg::PF_CODE, 7'h00, error_address_latch_i[22:0]}; // [R18]
				if (legacy_paging_i) begin
					pfw_q[22:psef_pkg::PF_LEGACY_LSB] <= 5'h00; // [R18]
				end
			end
		end
	end

	// Cache clearer sweep sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_q <= psef_pkg::PSEF_SW_IDLE;
			sweep_q <= '0;
		end else if (wr_sweep) begin
			sw_q <= psef_pkg::PSEF_SW_REQ; // [R24]
			sweep_q.req <= 1'b1;
			sweep_q.page <= wb_dat_i[psef_pkg::SW_PAGE_LSB +: 9];
			case (psef_pkg::psef_op_t'(wb_dat_i[psef_pkg::SW_OP_LSB +: 3]))
				psef_pkg::PSEF_OP_INV_ALL: begin
					sweep_q.whole <= 1'b1;
					sweep_q.writeback <= 1'b0; // [R23]
					sweep_q.invalidate <= 1'b1;
				end
				psef_pkg::PSEF_OP_WB_ALL: begin
					sweep_q.whole <= 1'b1;
					sweep_q.writeback <= 1'b1;
					sweep_q.invalidate <= 1'b0;
				end
				psef_pkg::PSEF_OP_UNLOAD_ALL: begin
					sweep_q.whole <= 1'b1;
					sweep_q.writeback <= 1'b1;
					sweep_q.invalidate <= 1'b1;
				end
				psef_pkg::PSEF_OP_INV_PAGE: begin
					sweep_q.whole <= 1'b0;
					sweep_q.writeback <= 1'b0;
					sweep_q.invalidate <= 1'b1;
				end
				psef_pkg::PSEF_OP_WB_PAGE: begin
					sweep_q.whole <= 1'b0;
					sweep_q.writeback <= 1'b1;
					sweep_q.invalidate <= 1'b0;
				end
				default: begin
					sweep_q.whole <= 1'b0;
					sweep_q.writeback <= 1'b1;
					sweep_q.invalidate <= 1'b1;
				end
			endcase
		end else begin
			case (sw_q)
				psef_pkg::PSEF_SW_IDLE: begin
					sweep_q.req <= 1'b0;
				end
				psef_pkg::PSEF_SW_REQ: begin
					if (memory_unit_response_i) begin
						sw_q <= psef_pkg::PSEF_SW_RUN; // [R24]
						sweep_q.req <= 1'b0;
					end
				end
				psef_pkg::PSEF_SW_RUN: begin
					if (sweep_done_i) begin
						sw_q <= psef_pkg::PSEF_SW_IDLE; // [R21]
					end
				end
				default: begin
					sw_q <= psef_pkg::PSEF_SW_IDLE;
					sweep_q.req <= 1'b0;
				end
			endcase
		end
	end

	// Outputs
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign flag_feedback_o = flags_q; // [R12]
	assign any_error_hold_o = hold_q;
	assign sweep_o = sweep_q;
	assign page_fault_o = pf_q;
	assign fault_word_o = pfw_q;
	assign fault_loc_o = psef_pkg::PF_TABLE_LOC; // [R18]
	assign pi_dismiss_o = dismiss_q;
	assign fetch_pc_o = fetch_pc_q;
	assign irq_o = irq_q;
	assign irq_chan_o = chan_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_irq_cause: assert property (irq_o |-> $past(|(flags_d & ena_q))) // [R2]
		else $error("interrupt without enabled flag");
	chk_ena_set: assert property ((wr_ctl && wdat[psef_pkg::ENA_SET_POS] && sel != 8'h00)
		|=> ((ena_q & $past(sel)) == $past(sel))) // [R3]
		else $error("enable set lost");
	chk_ena_clr: assert property ((wr_ctl && wdat[psef_pkg::ENA_CLR_POS]
		&& !wdat[psef_pkg::ENA_SET_POS]) |=> ((ena_q & $past(sel)) == 8'h00)) // [R4]
		else $error("enable clear lost");
	chk_ena_sticky: assert property ((!wr_ctl && ena_q[0]) |=> ena_q[0]) // [R5]
		else $error("enable dropped without clear");
	chk_adrpar_next: assert property ((mem_err_i.addr_parity && memory_unit_response_i)
		|=> flags_q[psef_pkg::F_ADRPAR] ##1 (irq_o || !ena_q[psef_pkg::F_ADRPAR])) // [R10]
		else $error("address parity flag or interrupt missing");
	chk_hold_track: assert property ((|(flags_q & psef_pkg::ERR_MASK)) |-> ##[0:1] hold_q) // [R12]
		else $error("error hold not raised");
	chk_hold_release: assert property ((flags_q & psef_pkg::ERR_MASK) == 8'h00 && $past(flags_d
		== flags_q) |-> !hold_q) // [R13]
		else $error("error hold not released");
	chk_sweep_flag: assert property ((sw_q == psef_pkg::PSEF_SW_RUN && sweep_done_i && !wr_sweep)
		|=> flags_q[psef_pkg::F_SWEEP] && sw_q == psef_pkg::PSEF_SW_IDLE) // [R21]
		else $error("sweep done flag missing");
	chk_inv_nowb: assert property ((wr_sweep // [R23]
		&& wb_dat_i[psef_pkg::SW_OP_LSB +: 3] == psef_pkg::PSEF_OP_INV_ALL)
		|=> (sweep_o.req && sweep_o.invalidate && !sweep_o.writeback))
		else $error("invalidate all writes back");
	chk_io_page_failure_flag_dismiss: assert property (pi_page_fail_i |=> pi_dismiss_o && flags_q[psef_pkg::F_IO_PAGE_FAILURE_FLAG]
		&& fetch_pc_o == $past(saved_pc_i)) // [R19]
		else $error("page failure in interrupt cycle mishandled");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule

// ===== verification/psef_mem_model.sv
// Behavioural memory control unit and adapter facing the status block
`timescale 1ns/10ps
module psef_mem_model #(
	parameter int TMO_CYC = 8000
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bench commands
	input wire psef_pkg::psef_mem_err_t inj_i,
	input wire logic [35:0] inj_adr_i,
	input wire logic [3:0] lat_i,
	// Status block side
	input wire psef_pkg::psef_sweep_t sweep_i,
	input wire logic any_error_hold_i,
	output psef_pkg::psef_mem_err_t mem_err_o,
	output logic response_o,
	output logic [35:0] era_o,
	output logic sweep_done_o
);
	logic [15:0] tmo_q;
	logic [4:0] sw_q;
	logic run_q, resp_err_q, resp_sw_q;
	assign response_o = resp_err_q | resp_sw_q;
	// Errors reported a cycle after the faulting request is acknowledged; absent memory only after the 2 * TMO_CYC timeout count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_err_o <= '0;
			resp_err_q <= 1'b0;
			tmo_q <= 16'h0000;
		end else begin
			mem_err_o <= inj_i;
			mem_err_o.absent <= (tmo_q == 16'h0001);
			resp_err_q <= inj_i.addr_parity | (tmo_q == 16'h0001);
			if (inj_i.absent) begin
				tmo_q <= 16'(2 * TMO_CYC);
			end else if (tmo_q != 16'h0000) begin
				tmo_q <= tmo_q - 16'h0001;
			end
		end
	end
	// Error address latch, frozen while the hold is up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			era_o <= 36'h0_0000_0000;
		end else if ((|inj_i) && !any_error_hold_i) begin
			era_o <= inj_adr_i;
		end
	end
	// Sweep: response after a delay, completion after another
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_q <= 5'h00;
			run_q <= 1'b0;
			resp_sw_q <= 1'b0;
			sweep_done_o <= 1'b0;
		end else begin
			resp_sw_q <= 1'b0;
			sweep_done_o <= 1'b0;
			if (sw_q != 5'h00) begin
				sw_q <= sw_q - 5'h01;
				if (sw_q == 5'h01) begin
					resp_sw_q <= !run_q;
					sweep_done_o <= run_q;
					run_q <= !run_q;
				end
			end else if ((sweep_i.req && !resp_sw_q) || run_q) begin
				sw_q <= {1'b0, lat_i} + 5'h01;
			end
		end
	end
endmodule

// ===== verification/psef_top_test.sv
// Self-checking bench for the processor status flag block
`timescale 1ns/10ps
module psef_top_test;
	localparam int TMO = 20;
	logic clk_i, rst_i, cyc, stb, we, pw, pif, lp, irq, ack, resp, sdone, hold, pf, dis;
	logic [7:0] adr, fb, mf, me;
	logic [31:0] wd, rd, rq, r;
	logic [35:0] ia, error_address_latch, a, fw;
	logic [22:0] spc, fpc;
	logic [3:0] lat, be;
	logic [2:0] ch, mc;
	logic [8:0] floc;
	psef_pkg::psef_mem_err_t inj, merr;
	psef_pkg::psef_sweep_t sw;
	int bad_count, total_checks, seed, pf_n, dis_n, n;
	int fmap [5] = '{psef_pkg::F_DIRPAR, psef_pkg::F_BUFPAR, psef_pkg::F_ADRPAR,
		psef_pkg::F_ABSENT, psef_pkg::F_BUS};
	psef_top psef_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .mem_err_i(merr), .memory_unit_response_i(resp),
		.error_address_latch_i(error_address_latch), .sweep_done_i(sdone), .flag_feedback_o(fb),
		.any_error_hold_o(hold), .sweep_o(sw), .legacy_paging_i(lp), .pi_page_fail_i(pif),
		.saved_pc_i(spc), .page_fault_o(pf), .fault_word_o(fw), .fault_loc_o(floc),
		.pi_dismiss_o(dis), .fetch_pc_o(fpc), .power_warn_i(pw), .irq_o(irq),
		.irq_chan_o(ch));
	psef_mem_model #(.TMO_CYC(TMO)) psef_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.inj_i(inj), .inj_adr_i(ia), .lat_i(lat), .sweep_i(sw), .any_error_hold_i(hold),
		.mem_err_o(merr), .response_o(resp), .era_o(error_address_latch), .sweep_done_o(sdone));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		pf_n += int'(pf === 1'b1);
		dis_n += int'(dis === 1'b1);
	end
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		wd <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 40);
		rq = rd;
		if (k >= 40) begin
			bad_count++;
			$display("Error at %0t: bus acknowledge timeout", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic cono(input logic [3:0] f, input logic [7:0] s, input logic [2:0] c);
		wb(1'b1, psef_pkg::CTRL_OFS, {16'h0000, f, s, 1'b0, c});
		if (f[1]) mf = mf & ~s;
		if (f[0]) mf = mf | s;
		if (f[2]) me = me & ~s;
		if (f[3]) me = me | s;
		mc = c;
	endtask
	task automatic verify();
		wb(1'b0, psef_pkg::CTRL_OFS, 32'h0000_0000);
		chk(rq, {15'h0000, |(mf & 8'hFE), 4'h0, mf, 1'b0, mc});
		wb(1'b0, psef_pkg::ENA_OFS, 32'h0000_0000);
		chk(rq, {20'h0_0000, me, 4'h0});
		chk(irq, |(mf & me));
		chk(fb, mf);
		chk(hold, |(mf & 8'hFE));
		chk(ch, mc);
	endtask
	task automatic hit(input logic [4:0] e, input logic [35:0] ad);
		@(posedge clk_i);
		inj <= psef_pkg::psef_mem_err_t'(e);
		ia <= ad;
		@(posedge clk_i);
		inj <= '0;
		repeat (2 * TMO + 8) @(posedge clk_i);
	endtask
	task automatic results();
		$display("Checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#240000;
		bad_count++;
		results();
	end
	initial begin
		seed = 63;
		{cyc, stb, we, pw, pif, adr, wd, ia, spc, lat, inj} = '0;
		lp = 1'b1;
		be = 4'hF;
		rst_i = 1'b1;
		mf = 8'h00;
		me = 8'h00;
		mc = 3'h0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		verify();
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			cono(r[3:0], r[11:4], r[14:12]);
			verify();
		end
		cono(4'b1010, 8'hFF, 3'h5);
		for (int k = 0; k < 5; k++) begin
			cono(4'b0010, 8'hFF, 3'h5);
			r = $random(seed);
			a = {r[3:0], r ^ 32'h5A5A_5A5A};
			hit(5'h01 << k, a);
			mf[fmap[k]] = 1'b1;
			verify();
			wb(1'b0, psef_pkg::ERAL_OFS, 32'h0000_0000);
			chk(rq, a[31:0]);
			if (k == 1) begin
				wb(1'b0, psef_pkg::PFWL_OFS, 32'h0000_0000);
				chk(rq, {2'b10, 7'h00, lp ? 5'h00 : a[22:18], a[17:0]});
				wb(1'b0, psef_pkg::PFWH_OFS, 32'h0000_0000);
				chk(rq, 32'h0000_0005);
				chk(floc, 9'h140);
				chk(fw, {6'h16, 7'h00, lp ? 5'h00 : a[22:18], a[17:0]});
			end
			hit(5'h01 << k, ~a);
			wb(1'b0, psef_pkg::ERAL_OFS, 32'h0000_0000);
			chk(rq, a[31:0]);
		end
		cono(4'b0010, 8'hFF, 3'h5);
		lp <= 1'b0;
		hit(5'h02, ~a);
		mf[psef_pkg::F_BUFPAR] = 1'b1;
		chk(fw, {6'h16, 7'h00, ~a[22:0]});
		chk(pf_n, 2);
		@(posedge clk_i);
		spc <= r[22:0];
		pif <= 1'b1;
		@(posedge clk_i);
		pif <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(dis_n, 1);
		chk(fpc, spc);
		mf[psef_pkg::F_IO_PAGE_FAILURE_FLAG] = 1'b1;
		verify();
		pw <= 1'b1;
		repeat (8) @(posedge clk_i);
		mf[psef_pkg::F_PWR] = 1'b1;
		verify();
		pw <= 1'b0;
		for (int op = 0; op < 6; op++) begin
			r = $random(seed);
			lat <= r[15:12];
			wb(1'b1, psef_pkg::SWEEP_OFS, {10'h000, 10'h00C, 3'(op), r[8:0]});
			n = 0;
			while (sw.req !== 1'b1 && n < 30) begin
				@(posedge clk_i);
				n++;
			end
			chk({sw.whole, sw.writeback, sw.invalidate, sw.page}, {op < 3,
				op == 1 || op == 2 || op == 4 || op == 5, op != 1 && op != 4, r[8:0]});
			repeat (40) @(posedge clk_i);
			mf[psef_pkg::F_SWEEP] = 1'b1;
			verify();
		end
		be <= 4'h7;
		wb(1'b1, psef_pkg::SWEEP_OFS, {10'h000, 10'h00C, 12'h000});
		be <= 4'hF;
		@(posedge clk_i);
		chk(sw.req, 1'b0);
		wb(1'b1, psef_pkg::SWEEP_OFS, {10'h000, 10'h00D, 12'h000});
		repeat (4) @(posedge clk_i);
		chk(sw.req, 1'b0);
		wb(1'b0, 8'hFC, 32'h0000_0000);
		chk(rq, 32'h0000_0000);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		mf = 8'h00;
		me = 8'h00;
		mc = 3'h0;
		verify();
		results();
	end
endmodule
